/* File: inc/pcv_pkg.sv */
// Package: constants and carrier types for program counter vectoring
`default_nettype none
package pcv_pkg;
  localparam int PC_W = 21;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam int DATA_ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CAUSE_W = 2;
  // Address space and vectors
  localparam logic [PC_W-1:0] RESET_VEC = 21'h000000;
  localparam logic [PC_W-1:0] HIGH_VEC = 21'h000008;
  localparam logic [PC_W-1:0] LOW_VEC = 21'h000018;
  localparam logic [PC_W-1:0] INSTR_BYTES = 21'h000002;
  localparam logic [PC_W-1:0] SPACE_TOP = 21'h1FFFFF;
  // On-chip program memory size range, in bytes
  localparam int PROG_BYTES_MIN = 32768;
  localparam int PROG_BYTES_MAX = 131072;
  localparam int PROG_BYTES_DEF = 131072;
  // Reset values and the full stack pointer
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_FULL = 5'h1F;
  localparam logic [WORD_W-1:0] NOP_WORD = 16'h0000;
  localparam logic [PC_W-1:0] PC_ZERO = 21'h000000;
  localparam logic [DATA_ADDR_W-1:0] DADDR_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 2'h0;
  // Field positions of the stored counter
  localparam int TOS_LOW_LSB = 0;
  localparam int TOS_HIGH_LSB = 8;
  localparam int TOS_UPPER_LSB = 16;
  localparam int TOS_UPPER_W = 5;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_RUN = 3'b010,
    ST_SLEEP = 3'b100
  } pcv_state_t;

  typedef struct packed {
    logic rd;
    logic [PC_W-1:0] addr;
  } pcv_fetch_req_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
  } pcv_fetch_rsp_t;

  typedef struct packed {
    logic clear;
    logic push;
    logic pop;
    logic [PC_W-1:0] value;
  } pcv_stack_cmd_t;
endpackage : pcv_pkg
`default_nettype wire

/* File: hw/pcv_return_stack.sv */
// Hardware return stack holding pushed program counter values
`default_nettype none
module pcv_return_stack (
  input wire logic clk,
  input wire logic rstn,
  input wire pcv_pkg::pcv_stack_cmd_t cmd,
  output logic [pcv_pkg::PC_W-1:0] tos,
  output logic [pcv_pkg::SP_W-1:0] ptr,
  output logic overflow,
  output logic underflow
);
  logic [pcv_pkg::PC_W-1:0] entry [1:pcv_pkg::STACK_DEPTH];
  logic [pcv_pkg::SP_W-1:0] ptr_up;
  logic [pcv_pkg::SP_W-1:0] ptr_dn;
  logic do_push;
  logic do_pop;

  assign ptr_up = ptr + 5'h01;
  assign ptr_dn = ptr - 5'h01;
  assign do_push = cmd.push && !cmd.clear && (ptr != pcv_pkg::SP_FULL);
  assign do_pop = cmd.pop && !cmd.clear && (ptr != pcv_pkg::SP_EMPTY);

  // Entry storage: a push writes the slot above the pointer
  genvar i;
  generate
    for (i = 1; i <= pcv_pkg::STACK_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          entry[i] <= pcv_pkg::PC_ZERO;
        end else if (do_push && (ptr_up == 5'(i))) begin
          entry[i] <= cmd.value;
        end
      end
    end
  endgenerate

  // Pointer and top copy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= pcv_pkg::SP_EMPTY;
      tos <= pcv_pkg::PC_ZERO;
    end else if (cmd.clear) begin
      ptr <= pcv_pkg::SP_EMPTY;
      tos <= pcv_pkg::PC_ZERO;
    end else if (do_push) begin
      ptr <= ptr_up;
      tos <= cmd.value;
    end else if (do_pop) begin
      ptr <= ptr_dn;
      tos <= (ptr_dn == pcv_pkg::SP_EMPTY) ? pcv_pkg::PC_ZERO : entry[ptr_dn];
    end
  end

  // Sticky fault flags, cleared only by a device reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflow <= 1'b0;
      underflow <= 1'b0;
    end else if (cmd.clear) begin
      overflow <= 1'b0;
      underflow <= 1'b0;
    end else begin
      if (cmd.push && ptr == pcv_pkg::SP_FULL) begin
        overflow <= 1'b1;
      end
      if (cmd.pop && ptr == pcv_pkg::SP_EMPTY) begin
        underflow <= 1'b1;
      end
    end
  end
endmodule : pcv_return_stack
`default_nettype wire

/* File: hw/pcv_fetch_port.sv */
// Program memory fetch port with zero fill above implemented memory
`default_nettype none
module pcv_fetch_port #(
  parameter int PROG_BYTES = pcv_pkg::PROG_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire pcv_pkg::pcv_fetch_req_t req,
  input wire logic [pcv_pkg::WORD_W-1:0] prog_rdata,
  output logic prog_rd,
  output logic [pcv_pkg::PC_W-1:0] prog_addr,
  output pcv_pkg::pcv_fetch_rsp_t rsp
);
  localparam logic [pcv_pkg::PC_W-1:0] PROG_LIMIT = pcv_pkg::PC_W'(PROG_BYTES);
  logic in_range;

  // Address drive toward the program memory bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_rd <= 1'b0;
      prog_addr <= pcv_pkg::PC_ZERO;
      in_range <= 1'b0;
    end else begin
      prog_rd <= req.rd;
      if (req.rd) begin
        prog_addr <= req.addr;
        in_range <= (req.addr < PROG_LIMIT);
      end
    end
  end

  // Returned word; unimplemented space reads as a no-operation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp.valid <= 1'b0;
      rsp.word <= pcv_pkg::NOP_WORD;
    end else begin
      rsp.valid <= prog_rd;
      if (prog_rd) begin
        rsp.word <= in_range ? prog_rdata : pcv_pkg::NOP_WORD;
      end
    end
  end
endmodule : pcv_fetch_port
`default_nettype wire

/* File: hw/pcv_core.sv */
// Program counter sequencing, vectoring and wake-up for the core
`default_nettype none
module pcv_core #(
  parameter int PROG_BYTES = pcv_pkg::PROG_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dev_reset_req,
  input wire logic step_req,
  input wire logic jump_req,
  input wire logic [pcv_pkg::PC_W-1:0] jump_target,
  input wire logic return_req,
  input wire logic sleep_req,
  input wire logic irq_high_flag,
  input wire logic irq_low_flag,
  input wire logic high_global_irq_enable,
  input wire logic low_global_irq_enable,
  input wire logic [pcv_pkg::WORD_W-1:0] prog_rdata,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [pcv_pkg::DATA_ADDR_W-1:0] data_addr_in,
  input wire logic [pcv_pkg::DATA_W-1:0] data_wdata_in,
  output logic [pcv_pkg::PC_W-1:0] program_counter,
  output logic prog_rd,
  output logic [pcv_pkg::PC_W-1:0] prog_addr,
  output logic [pcv_pkg::WORD_W-1:0] instr_word,
  output logic instr_valid,
  output logic data_rd,
  output logic data_wr,
  output logic [pcv_pkg::DATA_ADDR_W-1:0] data_addr,
  output logic [pcv_pkg::DATA_W-1:0] data_wdata,
  output logic [pcv_pkg::BYTE_W-1:0] stack_top_upper_byte,
  output logic [pcv_pkg::BYTE_W-1:0] stack_top_high_byte,
  output logic [pcv_pkg::BYTE_W-1:0] stack_top_low_byte,
  output logic [pcv_pkg::SP_W-1:0] return_stack_pointer,
  output logic stack_overflow,
  output logic stack_underflow,
  output logic asleep,
  output logic vector_taken,
  output logic [pcv_pkg::CAUSE_W-1:0] wake_cause
);
  pcv_pkg::pcv_state_t state;
  pcv_pkg::pcv_state_t next_state;
  logic [pcv_pkg::PC_W-1:0] next_pc;
  logic [pcv_pkg::PC_W-1:0] pc_plus;
  logic [pcv_pkg::PC_W-1:0] stack_tos;
  logic high_take;
  logic low_take;
  logic irq_any;
  logic gie_any;
  logic next_vector;
  logic wake_now;
  pcv_pkg::pcv_stack_cmd_t stack_cmd;
  pcv_pkg::pcv_fetch_req_t fetch_req;
  pcv_pkg::pcv_fetch_rsp_t fetch_rsp;

  // Interrupt qualification
  assign high_take = irq_high_flag && high_global_irq_enable;
  assign low_take = irq_low_flag && low_global_irq_enable;
  assign irq_any = irq_high_flag || irq_low_flag;
  assign gie_any = high_global_irq_enable || low_global_irq_enable;
  assign pc_plus = program_counter + pcv_pkg::INSTR_BYTES;

  // Next counter, state and stack command
  always_comb begin
    next_state = state;
    next_pc = program_counter;
    next_vector = 1'b0;
    wake_now = 1'b0;
    stack_cmd.clear = 1'b0;
    stack_cmd.push = 1'b0;
    stack_cmd.pop = 1'b0;
    stack_cmd.value = program_counter;
    fetch_req.rd = 1'b0;
    fetch_req.addr = program_counter;
    case (state)
      pcv_pkg::ST_BOOT: begin
        next_pc = pcv_pkg::RESET_VEC;
        next_state = pcv_pkg::ST_RUN;
      end
      pcv_pkg::ST_RUN: begin
        if (high_take) begin
          stack_cmd.push = 1'b1;
          next_pc = pcv_pkg::HIGH_VEC;
          next_vector = 1'b1;
        end else if (low_take) begin
          stack_cmd.push = 1'b1;
          next_pc = pcv_pkg::LOW_VEC;
          next_vector = 1'b1;
        end else if (sleep_req) begin
          next_state = pcv_pkg::ST_SLEEP;
        end else if (return_req) begin
          stack_cmd.pop = 1'b1;
          next_pc = {stack_tos[pcv_pkg::PC_W-1:1], 1'b0};
        end else if (jump_req) begin
          next_pc = {jump_target[pcv_pkg::PC_W-1:1], 1'b0};
        end else if (step_req) begin
          fetch_req.rd = 1'b1;
          next_pc = pc_plus;
        end
      end
      pcv_pkg::ST_SLEEP: begin
        if (irq_any) begin
          wake_now = 1'b1;
          next_state = pcv_pkg::ST_RUN;
          if (gie_any) begin
            stack_cmd.push = 1'b1;
            next_vector = 1'b1;
            if (irq_high_flag) begin
              next_pc = pcv_pkg::HIGH_VEC;
            end else begin
              next_pc = pcv_pkg::LOW_VEC;
            end
          end
        end
      end
      default: begin
        next_state = pcv_pkg::ST_BOOT;
        next_pc = pcv_pkg::RESET_VEC;
      end
    endcase
    if (dev_reset_req) begin
      next_state = pcv_pkg::ST_BOOT;
      next_pc = pcv_pkg::RESET_VEC;
      next_vector = 1'b0;
      wake_now = 1'b0;
      stack_cmd.clear = 1'b1;
      stack_cmd.push = 1'b0;
      stack_cmd.pop = 1'b0;
      fetch_req.rd = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= pcv_pkg::ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // Program counter, 21 bits across the whole space
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      program_counter <= pcv_pkg::RESET_VEC;
    end else begin
      program_counter <= next_pc & pcv_pkg::SPACE_TOP;
    end
  end

  // Sleep indication and vector pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      asleep <= 1'b0;
      vector_taken <= 1'b0;
    end else begin
      asleep <= (next_state == pcv_pkg::ST_SLEEP);
      vector_taken <= next_vector;
    end
  end

  // Records which flags ended sleep; the flags themselves are untouched
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_cause <= pcv_pkg::CAUSE_NONE;
    end else if (dev_reset_req) begin
      wake_cause <= pcv_pkg::CAUSE_NONE;
    end else if (wake_now) begin
      wake_cause <= {irq_high_flag, irq_low_flag};
    end
  end

  // Data memory bus, independent of the fetch bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      data_addr <= pcv_pkg::DADDR_ZERO;
      data_wdata <= pcv_pkg::DATA_ZERO;
    end else begin
      data_rd <= data_req && !data_write && !asleep;
      data_wr <= data_req && data_write && !asleep;
      if (data_req) begin
        data_addr <= data_addr_in;
        data_wdata <= data_wdata_in;
      end
    end
  end

  // Top-of-stack bytes follow the stack copy
  always_comb begin
    stack_top_low_byte = stack_tos[pcv_pkg::TOS_LOW_LSB +: pcv_pkg::BYTE_W];
    stack_top_high_byte = stack_tos[pcv_pkg::TOS_HIGH_LSB +: pcv_pkg::BYTE_W];
    stack_top_upper_byte = {3'h0, stack_tos[pcv_pkg::TOS_UPPER_LSB +: pcv_pkg::TOS_UPPER_W]};
  end

  assign instr_word = fetch_rsp.word;
  assign instr_valid = fetch_rsp.valid;

  pcv_return_stack u_stack (
    .clk(clk),
    .rstn(rstn),
    .cmd(stack_cmd),
    .tos(stack_tos),
    .ptr(return_stack_pointer),
    .overflow(stack_overflow),
    .underflow(stack_underflow)
  );

  pcv_fetch_port #(
    .PROG_BYTES(PROG_BYTES)
  ) u_fetch (
    .clk(clk),
    .rstn(rstn),
    .req(fetch_req),
    .prog_rdata(prog_rdata),
    .prog_rd(prog_rd),
    .prog_addr(prog_addr),
    .rsp(fetch_rsp)
  );
endmodule : pcv_core
`default_nettype wire

/* File: tb/pcv_core_asserts.sv */
// Concurrent checks on the program counter vectoring core ports
`default_nettype none
module pcv_core_asserts #(
  parameter int PROG_BYTES = pcv_pkg::PROG_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dev_reset_req,
  input wire logic irq_high_flag,
  input wire logic irq_low_flag,
  input wire logic high_global_irq_enable,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [pcv_pkg::DATA_ADDR_W-1:0] data_addr_in,
  input wire logic [pcv_pkg::PC_W-1:0] program_counter,
  input wire logic prog_rd,
  input wire logic [pcv_pkg::PC_W-1:0] prog_addr,
  input wire logic [pcv_pkg::WORD_W-1:0] instr_word,
  input wire logic instr_valid,
  input wire logic data_rd,
  input wire logic [pcv_pkg::DATA_ADDR_W-1:0] data_addr,
  input wire logic [pcv_pkg::BYTE_W-1:0] stack_top_upper_byte,
  input wire logic [pcv_pkg::BYTE_W-1:0] stack_top_high_byte,
  input wire logic [pcv_pkg::BYTE_W-1:0] stack_top_low_byte,
  input wire logic [pcv_pkg::SP_W-1:0] return_stack_pointer,
  input wire logic stack_overflow,
  input wire logic asleep,
  input wire logic vector_taken,
  input wire logic [pcv_pkg::CAUSE_W-1:0] wake_cause
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence hi_take;
    vector_taken && $past(irq_high_flag && high_global_irq_enable);
  endsequence
  sequence hi_fetch;
    prog_rd && prog_addr >= PROG_BYTES;
  endsequence
  sequence wake_edge;
    $fell(asleep) && !$past(dev_reset_req);
  endsequence
  chk_dev_reset:
    assert property (dev_reset_req && !asleep |=> program_counter == pcv_pkg::RESET_VEC
      && return_stack_pointer == pcv_pkg::SP_EMPTY) else $error("device reset missed");
  chk_high_vec:
    assert property (hi_take |-> program_counter == pcv_pkg::HIGH_VEC)
    else $error("high vector wrong");
  chk_low_vec:
    assert property (vector_taken && !$past(irq_high_flag) |-> program_counter == pcv_pkg::LOW_VEC)
    else $error("low vector wrong");
  chk_step_adv:
    assert property (prog_rd |-> program_counter == prog_addr + pcv_pkg::INSTR_BYTES)
    else $error("counter not two past fetch");
  chk_nop_above:
    assert property (hi_fetch |=> instr_valid && instr_word == pcv_pkg::NOP_WORD)
    else $error("fetch above memory not zero");
  chk_push_tos:
    assert property (vector_taken && !stack_overflow |-> {stack_top_upper_byte,
      stack_top_high_byte, stack_top_low_byte} == {3'b000, $past(program_counter)}
      && return_stack_pointer == $past(return_stack_pointer) + 5'h01)
    else $error("push wrong");
  chk_wake_cause:
    assert property (wake_edge |-> wake_cause == $past({irq_high_flag, irq_low_flag})
      && wake_cause != pcv_pkg::CAUSE_NONE) else $error("wake cause wrong");
  chk_data_bus:
    assert property (data_req && !asleep |=> data_rd == !$past(data_write)
      && data_addr == $past(data_addr_in)) else $error("data access wrong");
endmodule : pcv_core_asserts
bind pcv_core pcv_core_asserts #(.PROG_BYTES(PROG_BYTES)) u_pcv_core_asserts (.clk, .rstn,
  .dev_reset_req, .irq_high_flag, .irq_low_flag, .high_global_irq_enable, .data_req,
  .data_write, .data_addr_in, .program_counter, .prog_rd, .prog_addr, .instr_word, .instr_valid,
  .data_rd, .data_addr, .stack_top_upper_byte, .stack_top_high_byte, .stack_top_low_byte,
  .return_stack_pointer, .stack_overflow, .asleep, .vector_taken, .wake_cause);
`default_nettype wire

/* File: tb/pcv_prog_mem.sv */
// Program memory model answering each fetch combinationally in the same cycle
`default_nettype none
module pcv_prog_mem (
  input wire logic clk,
  input wire logic prog_rd,
  input wire logic [20:0] prog_addr,
  output logic [15:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] junk = 16'hA55A;
  always @(posedge clk) junk <= ~junk;
  // Separate fetch path; idle cycles show changing junk
  assign prog_rdata = prog_rd ? (prog_addr[16:1] ^ 16'h5A3C) : junk;
endmodule : pcv_prog_mem
`default_nettype wire

/* File: tb/pcv_core_tb.sv */
// Self-checking testbench for the program counter vectoring core
`default_nettype none
module pcv_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PB = 32768;
  logic clk = 0, rstn = 0, step_req = 0, data_req = 0, data_write = 0;
  logic [7:0] rq = 8'h00;
  logic dev_reset_req, jump_req, return_req, sleep_req, irq_high_flag, irq_low_flag;
  logic high_global_irq_enable, low_global_irq_enable, prog_rd, instr_valid, data_rd, data_wr;
  logic stack_overflow, stack_underflow, asleep, vector_taken;
  logic [20:0] jump_target = '0, program_counter, prog_addr;
  logic [15:0] prog_rdata, instr_word;
  logic [11:0] data_addr_in = '0, data_addr;
  logic [7:0] data_wdata_in = '0, data_wdata, stack_top_upper_byte, stack_top_high_byte;
  logic [7:0] stack_top_low_byte;
  logic [7:0] wk [3] = '{8'h05, 8'h09, 8'h04};
  logic [4:0] return_stack_pointer;
  logic ov = 1'b0;
  logic [1:0] wake_cause;
  int fail_count = 0, n_compared = 0, pc = 0, a;
  int stk[$], fq[$], tg[4];
  assign {dev_reset_req, jump_req, return_req, sleep_req, irq_high_flag, irq_low_flag,
    high_global_irq_enable, low_global_irq_enable} = rq;
  always #5 clk = ~clk;
  pcv_core #(.PROG_BYTES(PB)) u_pcv_core (.clk, .rstn, .dev_reset_req, .step_req, .jump_req,
    .jump_target, .return_req, .sleep_req, .irq_high_flag, .irq_low_flag, .high_global_irq_enable,
    .low_global_irq_enable, .prog_rdata, .data_req, .data_write, .data_addr_in, .data_wdata_in,
    .program_counter, .prog_rd, .prog_addr, .instr_word, .instr_valid, .data_rd, .data_wr,
    .data_addr, .data_wdata, .stack_top_upper_byte, .stack_top_high_byte, .stack_top_low_byte,
    .return_stack_pointer, .stack_overflow, .stack_underflow, .asleep, .vector_taken, .wake_cause);
  pcv_prog_mem u_pcv_prog_mem (.clk, .prog_rd, .prog_addr, .prog_rdata);
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task req(input logic [7:0] v, input logic [20:0] t);
    @(posedge clk);
    rq <= v;
    jump_target <= t;
    @(posedge clk);
    rq <= 8'h00;
    #1;
  endtask : req
  task chkst;
    chk("pc", program_counter, pc);
    chk("ptr", return_stack_pointer, stk.size());
    if (stk.size() > 0) chk("tos", {stack_top_upper_byte, stack_top_high_byte,
      stack_top_low_byte}, stk[$]);
  endtask : chkst
  task vec(input logic [7:0] v, input int dst);
    if (dst >= 0) begin
      stk.push_back(pc);
      pc = dst;
    end
    req(v, 21'h000000);
    chk("vector", vector_taken, dst >= 0);
    chkst;
  endtask : vec
  task steps(input int k, input logic dq);
    @(posedge clk);
    step_req <= 1'b1;
    data_req <= dq;
    data_write <= k[0];
    data_addr_in <= 12'($urandom);
    data_wdata_in <= 8'($urandom);
    for (int i = 0; i < k + 2; i++) begin
      @(posedge clk);
      data_req <= 1'b0;
      if (i == k - 1) step_req <= 1'b0;
      #1;
      if (i == 0) begin
        chk("dwr", {data_wr, data_rd}, {dq & k[0], dq & !k[0]});
        if (dq) chk("daddr", {data_addr, data_wdata}, {data_addr_in, data_wdata_in});
      end
      if (i < k) begin
        fq.push_back(pc);
        chk("fetch", {prog_rd, prog_addr}, {1'b1, 21'(pc)});
        pc = (pc + 2) % 32'h200000;
        chk("pc", program_counter, pc);
      end
      if (instr_valid) begin
        a = fq.pop_front();
        chk("word", instr_word, a < PB ? ((a >> 1) & 16'hFFFF) ^ 16'h5A3C : 0);
      end
    end
    chk("fetches", fq.size(), 0);
  endtask : steps
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
  initial begin
    a = $urandom(670);
    tg = '{32'h1FFFFF, $urandom_range(0, PB - 2), PB - 4, $urandom_range(PB, 32'h1FFFFF)};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chkst;
    $display("test reset done");
    foreach (tg[i]) begin
      pc = tg[i] & 32'h1FFFFE;
      req(8'h40, 21'(tg[i]));
      chkst;
      steps($urandom_range(2, 6), i[0]);
    end
    $display("test fetch done");
    vec(8'h0A, 8);
    vec(8'h05, 24);
    vec(8'h06, -1);
    pc = stk.pop_back();
    req(8'h20, 21'h000000);
    chkst;
    $display("test interrupt done");
    for (int i = 0; i < 3; i++) begin
      req(8'h10, 21'h000000);
      chk("sleep", asleep, 1);
      vec(wk[i], i == 2 ? -1 : (i == 1 ? 8 : 24));
      chk("awake", {asleep, wake_cause}, {1'b0, wk[i][3:2]});
    end
    $display("test wake done");
    for (int j = 0; j < 30; j++) begin
      if (stk.size() < 31) stk.push_back(pc);
      else ov = 1'b1;
      pc = 8;
      req(8'h0A, 21'h000000);
      chk("ovf", {stack_overflow, stack_underflow}, {ov, 1'b0});
      chkst;
    end
    $display("test overflow done");
    req(8'h80, 21'h000000);
    pc = 0;
    stk = {};
    chkst;
    chk("flags", {stack_overflow, stack_underflow}, 2'b00);
    req(8'h20, 21'h000000);
    chkst;
    chk("unf", {stack_overflow, stack_underflow, vector_taken}, 3'b010);
    $display("test device reset done");
    final_report;
  end
endmodule : pcv_core_tb
`default_nettype wire
